// ===== uaf_pkg.sv
// constants and types for the serial-port address-recognition filter
// Function
// - recognition works only while multiproc_enable in serial_control is set
// - with recognition on, receive_flag is set only for frames matching this node
// - in mode 1 with recognition on, the stop bit stands in for the ninth bit
// - mode 1 with recognition sets receive_flag only on match and valid stop
// - mode 0 ignores multiproc_enable; no recognition in shift-register mode
// - given address compares own_address_byte only where address_mask_byte bits are one
// - an address frame is accepted on given-address or broadcast-address match
// - modes 2 and 3 store the ninth bit of accepted frames into received_ninth_bit
package uaf_pkg;

    // apb register byte addresses
    localparam logic [7:0] UAF_OFS_CONTROL  = 8'h00;
    localparam logic [7:0] UAF_OFS_OWN_ADDR = 8'h04;
    localparam logic [7:0] UAF_OFS_MASK     = 8'h08;
    localparam logic [7:0] UAF_OFS_RX_DATA  = 8'h0c;
    localparam logic [7:0] UAF_OFS_STATUS   = 8'h10;
    localparam logic [7:0] UAF_OFS_ENABLE   = 8'h14;
    localparam logic [7:0] UAF_OFS_CLEAR    = 8'h18;

    // serial_control field positions
    localparam int UAF_SC_RECV_FLAG  = 0;
    localparam int UAF_SC_XMIT_FLAG  = 1;
    localparam int UAF_SC_NINTH_RX   = 2;
    localparam int UAF_SC_NINTH_TX   = 3;
    localparam int UAF_SC_RX_ENABLE  = 4;
    localparam int UAF_SC_MULTIPROC  = 5;
    localparam int UAF_SC_MODE_LO    = 6;
    localparam int UAF_SC_MODE_HI    = 7;

    // reset values
    localparam logic [7:0] UAF_RST_CONTROL = 8'h00;
    localparam logic [7:0] UAF_RST_BYTE    = 8'h00;

    // serial port modes
    typedef enum logic [1:0] {
        UAF_MODE_SHIFT = 2'b00,
        UAF_MODE_8BIT  = 2'b01,
        UAF_MODE_9BIT  = 2'b10,
        UAF_MODE_9VAR  = 2'b11
    } uaf_mode_t;

    // interrupt event bit positions
    localparam int UAF_EV_ACCEPT  = 0;
    localparam int UAF_EV_MISS    = 1;
    localparam int UAF_EV_OVERRUN = 2;
    localparam int UAF_EV_STOPERR = 3;
    localparam int UAF_EV_COUNT   = 4;

endpackage

// ===== uaf_addr_match.sv
// address comparator: given address and broadcast address
module uaf_addr_match #(
    parameter int WIDTH = 8
) (
    // frame and address bytes
    input  wire logic [WIDTH-1:0] rx_byte,
    input  wire logic [WIDTH-1:0] own_address_byte,
    input  wire logic [WIDTH-1:0] address_mask_byte,
    // results
    output logic                  given_hit,
    output logic                  broadcast_hit
);

    // compare only where care bits are one
    function automatic logic masked_eq(input logic [WIDTH-1:0] a,
                                       input logic [WIDTH-1:0] b,
                                       input logic [WIDTH-1:0] care);
        masked_eq = ((a ^ b) & care) == '0;
    endfunction

    logic [WIDTH-1:0] broadcast;

    assign broadcast     = own_address_byte | address_mask_byte;
    assign given_hit     = masked_eq(rx_byte, own_address_byte, address_mask_byte);
    assign broadcast_hit = masked_eq(rx_byte, broadcast, broadcast);

endmodule

// ===== uaf_irq_ctrl.sv
// sticky event status, enable mask and level interrupt
module uaf_irq_ctrl #(
    parameter int N = 4
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         srst,
    // events, one-cycle pulses
    input  wire logic [N-1:0] event_in,
    // software access
    input  wire logic         enable_we,
    input  wire logic [N-1:0] enable_wdata,
    input  wire logic         clear_we,
    input  wire logic [N-1:0] clear_wdata,
    // state
    output logic      [N-1:0] status,
    output logic      [N-1:0] enable,
    output logic              irq
);

    logic [N-1:0] next_status;
    logic [N-1:0] next_enable;
    logic         next_irq;

    // a set arriving with its clear wins, so no event is lost
    always_comb begin
        next_status = (clear_we ? (status & ~clear_wdata) : status) | event_in;
        next_enable = enable_we ? enable_wdata : enable;
        next_irq    = |(next_status & next_enable);
    end

    // registers
    always_ff @(posedge clock) begin
        if (srst) begin
            status <= '0;
            enable <= '0;
            irq    <= 1'b0;
        end else begin
            status <= next_status;
            enable <= next_enable;
            irq    <= next_irq;
        end
    end

endmodule

// ===== uaf_top.sv
// serial receiver address-recognition filter with apb registers
module uaf_top
    import uaf_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              srst,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // frames from the receiver shifter, same clock
    input  wire logic              frame_done,
    input  wire logic [7:0]        frame_byte,
    input  wire logic              frame_bit9,
    input  wire logic              frame_stop_ok,
    // control towards the rest of the port
    output logic      [1:0]        serial_mode,
    output logic                   multiproc_enable,
    output logic                   rx_enable,
    output logic                   tx_ninth_bit,
    // receive state
    output logic                   receive_flag,
    output logic                   received_ninth_bit,
    // interrupt
    output logic                   irq
);

    // apb access qualification
    // one setup cycle, one access cycle, then pready after a single wait state
    // a transfer never stalls longer, so no timeout logic is needed here
    logic              access;
    logic              wr_commit;
    logic              rd_commit;
    logic [7:0]        reg_addr;

    // one wait state: pready rises on the second access-phase cycle
    assign access    = psel & penable;
    assign wr_commit = access & pready & pwrite;
    assign rd_commit = access & ~pready & ~pwrite;
    assign reg_addr  = paddr[7:0];

    // address hit helper, used by read and write decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // known address check
    function automatic logic mapped(input logic [7:0] a);
        mapped = hit(a, UAF_OFS_CONTROL) | hit(a, UAF_OFS_OWN_ADDR)
               | hit(a, UAF_OFS_MASK) | hit(a, UAF_OFS_RX_DATA)
               | hit(a, UAF_OFS_STATUS) | hit(a, UAF_OFS_ENABLE)
               | hit(a, UAF_OFS_CLEAR);
    endfunction

    // register state
    // software-visible bytes plus the interrupt status and enable words
    // rx_data is read-only: software writes to it are dropped without error
    logic [7:0]        serial_control;
    logic [7:0]        own_address_byte;
    logic [7:0]        address_mask_byte;
    logic [7:0]        rx_data;
    logic [7:0]        next_serial_control;
    logic [7:0]        next_own_address_byte;
    logic [7:0]        next_address_mask_byte;
    logic [7:0]        next_rx_data;

    logic [UAF_EV_COUNT-1:0] irq_status;
    logic [UAF_EV_COUNT-1:0] irq_enable;
    logic [UAF_EV_COUNT-1:0] events;
    logic                    en_we;
    logic                    clr_we;

    // frame filtering
    // frames come from the shifter on this clock, so no synchroniser sits here
    // rx_enable low drops a frame before any address check is made
    uaf_mode_t         mode;
    logic              sm_on;
    logic              given_hit;
    logic              broadcast_hit;
    logic              addr_hit;
    logic              take_frame;
    logic              miss_frame;
    logic              stop_err;
    logic              load_ninth;
    logic              ninth_value;
    logic              frame_in;

    assign mode     = uaf_mode_t'(serial_control[UAF_SC_MODE_HI:UAF_SC_MODE_LO]);
    assign frame_in = frame_done & serial_control[UAF_SC_RX_ENABLE];

    assign sm_on = serial_control[UAF_SC_MULTIPROC] & (mode != UAF_MODE_SHIFT);

    uaf_addr_match #(
        .WIDTH            (8)
    ) u_match (
        .rx_byte          (frame_byte),
        .own_address_byte (own_address_byte),
        .address_mask_byte(address_mask_byte),
        .given_hit        (given_hit),
        .broadcast_hit    (broadcast_hit)
    );

    // given or broadcast address is enough
    assign addr_hit = given_hit | broadcast_hit;

    // decide what a finished frame does to the flag and ninth bit
    always_comb begin
        take_frame  = 1'b0;
        miss_frame  = 1'b0;
        stop_err    = 1'b0;
        load_ninth  = 1'b0;
        ninth_value = 1'b0;
        if (frame_in) begin
            case (mode)
                UAF_MODE_SHIFT: begin
                    take_frame = 1'b1;
                end
                UAF_MODE_8BIT: begin
                    if (sm_on) begin
                        // stop bit acts as the address marker
                        // valid stop and matching address both needed
                        take_frame = frame_stop_ok & addr_hit;
                        miss_frame = frame_stop_ok & ~addr_hit;
                        stop_err   = ~frame_stop_ok;
                    end else begin
                        // plain mode 1: ninth flag holds the stop bit
                        take_frame  = 1'b1;
                        load_ninth  = 1'b1;
                        ninth_value = frame_stop_ok;
                    end
                end
                default: begin
                    if (sm_on) begin
                        // data frames and foreign addresses dropped
                        take_frame = frame_bit9 & addr_hit;
                        miss_frame = frame_bit9 & ~addr_hit;
                    end else begin
                        take_frame = 1'b1;
                    end
                    // capture the ninth bit of accepted frames
                    load_ninth  = take_frame;
                    ninth_value = frame_bit9;
                end
            endcase
        end
    end

    // register next values
    // software writes first, hardware updates after, so a frame is never lost
    // software may also set receive_flag; hardware never clears it
    always_comb begin
        next_serial_control    = serial_control;
        next_own_address_byte  = own_address_byte;
        next_address_mask_byte = address_mask_byte;
        next_rx_data           = rx_data;
        if (wr_commit) begin
            if (hit(reg_addr, UAF_OFS_CONTROL)) begin
                next_serial_control = pwdata[7:0];
            end else if (hit(reg_addr, UAF_OFS_OWN_ADDR)) begin
                next_own_address_byte = pwdata[7:0];
            end else if (hit(reg_addr, UAF_OFS_MASK)) begin
                // all ones here selects a single address
                next_address_mask_byte = pwdata[7:0];
            end
        end
        // hardware updates come last so they win over a software write
        if (take_frame) begin
            next_rx_data = frame_byte;
            // hardware only ever sets the flag
            next_serial_control[UAF_SC_RECV_FLAG] = 1'b1;
        end
        if (load_ninth) begin
            next_serial_control[UAF_SC_NINTH_RX] = ninth_value;
        end
    end

    // control and address registers
    always_ff @(posedge clock) begin
        if (srst) begin
            serial_control    <= UAF_RST_CONTROL;
            own_address_byte  <= UAF_RST_BYTE;
            address_mask_byte <= UAF_RST_BYTE;
            rx_data           <= UAF_RST_BYTE;
        end else begin
            serial_control    <= next_serial_control;
            own_address_byte  <= next_own_address_byte;
            address_mask_byte <= next_address_mask_byte;
            rx_data           <= next_rx_data;
        end
    end

    // interrupt events
    // each event is a one-cycle pulse into the sticky status word
    // miss and stop-error events only fire while filtering is active
    // overrun: a new frame accepted while the flag is still pending
    always_comb begin
        events                 = '0;
        events[UAF_EV_ACCEPT]  = take_frame;
        events[UAF_EV_MISS]    = miss_frame;
        events[UAF_EV_OVERRUN] = take_frame & serial_control[UAF_SC_RECV_FLAG];
        events[UAF_EV_STOPERR] = stop_err;
    end

    assign en_we  = wr_commit & hit(reg_addr, UAF_OFS_ENABLE);
    assign clr_we = wr_commit & hit(reg_addr, UAF_OFS_CLEAR);

    uaf_irq_ctrl #(
        .N           (UAF_EV_COUNT)
    ) u_irq (
        .clock       (clock),
        .srst        (srst),
        .event_in    (events),
        .enable_we   (en_we),
        .enable_wdata(pwdata[UAF_EV_COUNT-1:0]),
        .clear_we    (clr_we),
        .clear_wdata (pwdata[UAF_EV_COUNT-1:0]),
        .status      (irq_status),
        .enable      (irq_enable),
        .irq         (irq)
    );

    // apb response
    // all bus outputs are registered to keep paths from the decode short
    // unmapped addresses answer with pslverr and read back as zero
    logic [31:0]       next_prdata;
    logic              next_pready;
    logic              next_pslverr;

    // read data is captured one cycle before pready, so it is steady
    always_comb begin
        next_prdata  = prdata;
        next_pready  = access & ~pready;
        next_pslverr = 1'b0;
        if (access & ~pready) begin
            next_pslverr = ~mapped(reg_addr);
        end
        if (rd_commit) begin
            next_prdata = 32'h0000_0000;
            if (hit(reg_addr, UAF_OFS_CONTROL)) begin
                next_prdata[7:0] = serial_control;
            end else if (hit(reg_addr, UAF_OFS_OWN_ADDR)) begin
                next_prdata[7:0] = own_address_byte;
            end else if (hit(reg_addr, UAF_OFS_MASK)) begin
                next_prdata[7:0] = address_mask_byte;
            end else if (hit(reg_addr, UAF_OFS_RX_DATA)) begin
                next_prdata[7:0] = rx_data;
            end else if (hit(reg_addr, UAF_OFS_STATUS)) begin
                next_prdata[UAF_EV_COUNT-1:0] = irq_status;
            end else if (hit(reg_addr, UAF_OFS_ENABLE)) begin
                next_prdata[UAF_EV_COUNT-1:0] = irq_enable;
            end
        end
    end

    // bus response registers
    always_ff @(posedge clock) begin
        if (srst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // control outputs
    // taken straight from the control register flops, no extra delay
    // the transmit flag bit is plain storage in this block
    assign serial_mode        = serial_control[UAF_SC_MODE_HI:UAF_SC_MODE_LO];
    assign multiproc_enable   = serial_control[UAF_SC_MULTIPROC];
    assign rx_enable          = serial_control[UAF_SC_RX_ENABLE];
    assign tx_ninth_bit       = serial_control[UAF_SC_NINTH_TX];
    assign receive_flag       = serial_control[UAF_SC_RECV_FLAG];
    assign received_ninth_bit = serial_control[UAF_SC_NINTH_RX];

endmodule

// ===== uaf_monitor.sv
// checker for the address filter: frame acceptance, flags and ninth bit
module uaf_monitor
    import uaf_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic              clock,
    input wire logic              srst,
    // apb request and answer
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              pready,
    // frames
    input wire logic              frame_done,
    input wire logic [7:0]        frame_byte,
    input wire logic              frame_bit9,
    input wire logic              frame_stop_ok,
    // receive state
    input wire logic [1:0]        serial_mode,
    input wire logic              multiproc_enable,
    input wire logic              rx_enable,
    input wire logic              receive_flag,
    input wire logic              received_ninth_bit
);
    logic [7:0] own_s;
    logic [7:0] mask_s;
    logic [7:0] bc;
    logic       wr_done;
    logic       ctl_wr;
    logic       take;
    logic       filt;
    logic       hit_g;
    logic       hit_b;

    // a control write in the same edge may clear the flag, so it is excluded
    assign wr_done = psel && penable && pready && pwrite;
    assign ctl_wr  = wr_done && paddr[7:0] == UAF_OFS_CONTROL;
    assign take    = frame_done && rx_enable;
    assign filt    = take && multiproc_enable && serial_mode != UAF_MODE_SHIFT && !ctl_wr;
    assign bc      = own_s | mask_s;
    assign hit_g   = ((frame_byte ^ own_s) & mask_s) == 8'h00;
    assign hit_b   = ((frame_byte ^ bc) & bc) == 8'h00;

    // shadow copies of the address bytes, taken on completed writes only
    always_ff @(posedge clock) begin
        if (srst) begin
            own_s  <= 8'h00;
            mask_s <= 8'h00;
        end else if (wr_done && paddr[7:0] == UAF_OFS_OWN_ADDR) begin
            own_s  <= pwdata[7:0];
        end else if (wr_done && paddr[7:0] == UAF_OFS_MASK) begin
            mask_s <= pwdata[7:0];
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    chk_shift_accept:
        assert property (take && serial_mode == UAF_MODE_SHIFT |=> receive_flag)
        else $error("shift mode frame did not set the flag");
    chk_open_accept:
        assert property (take && !multiproc_enable |=> receive_flag)
        else $error("unfiltered frame did not set the flag");
    chk_miss_quiet:
        assert property (filt && !receive_flag && !(hit_g || hit_b) |=> !receive_flag)
        else $error("foreign address set the flag");
    chk_stop_gate:
        assert property (filt && serial_mode == UAF_MODE_8BIT && !frame_stop_ok
            && !receive_flag |=> !receive_flag)
        else $error("bad stop bit set the flag");
    chk_stop_hit:
        assert property (filt && serial_mode == UAF_MODE_8BIT && frame_stop_ok
            && (hit_g || hit_b) |=> receive_flag)
        else $error("matching frame with good stop ignored");
    chk_given_hit:
        assert property (filt && serial_mode[1] && frame_bit9 && hit_g
            |=> receive_flag && received_ninth_bit)
        else $error("given address match ignored");
    chk_bcast_hit:
        assert property (filt && serial_mode[1] && frame_bit9 && hit_b |=> receive_flag)
        else $error("broadcast address match ignored");
    chk_ninth_load:
        assert property (take && serial_mode[1] && !multiproc_enable
            |=> received_ninth_bit == $past(frame_bit9))
        else $error("ninth bit not stored");
    chk_stop_ninth:
        assert property (take && serial_mode == UAF_MODE_8BIT && !multiproc_enable
            |=> received_ninth_bit == $past(frame_stop_ok))
        else $error("stop bit not stored as ninth bit");
    chk_flag_sticky:
        assert property (receive_flag && !ctl_wr |=> receive_flag)
        else $error("flag dropped without software");
endmodule

bind uaf_top uaf_monitor #(.ADDR_W(ADDR_W)) u_mon (
    .clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .frame_done(frame_done),
    .frame_byte(frame_byte), .frame_bit9(frame_bit9), .frame_stop_ok(frame_stop_ok),
    .serial_mode(serial_mode), .multiproc_enable(multiproc_enable),
    .rx_enable(rx_enable), .receive_flag(receive_flag),
    .received_ninth_bit(received_ninth_bit)
);

// ===== uaf_peer.sv
// model of a remote processor handing frames to the receiver
module uaf_peer (
    // clock
    input  wire logic       clock,
    // frame towards the filter
    output logic            frame_done,
    output logic [7:0]      frame_byte,
    output logic            frame_bit9,
    output logic            frame_stop_ok
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        frame_done    = 1'b0;
        frame_byte    = 8'h00;
        frame_bit9    = 1'b0;
        frame_stop_ok = 1'b0;
    end

    // one-cycle frame; fields are inverted afterwards so stale data never looks valid
    task automatic send(input logic [7:0] b, input logic n, input logic s);
        @(posedge clock);
        frame_done    <= 1'b1;
        frame_byte    <= b;
        frame_bit9    <= n;
        frame_stop_ok <= s;
        @(posedge clock);
        frame_done    <= 1'b0;
        frame_byte    <= ~b;
        frame_bit9    <= ~n;
        frame_stop_ok <= ~s;
    endtask
endmodule

// ===== tb_uart_address_filter.sv
// self-checking bench for the address filter
module tb_uart_address_filter
    import uaf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clock;
    logic        srst;
    logic        psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, rxd;
    logic        pready, pslverr, er;
    logic        frame_done, frame_bit9, frame_stop_ok;
    logic [7:0]  frame_byte;
    logic        receive_flag, received_ninth_bit, irq;
    logic [1:0]  serial_mode;
    logic        multiproc_enable, rx_enable, tx_ninth_bit;
    int          err_total, cmp_count;
    // rows: control, own, mask, byte, {bit9, stop, flag, ninth}; single-address rows mask ff
    logic [35:0] rows [13] = '{36'h3056ff12e, 36'h5056ff127, 36'h7056ff566,
        36'h7056ff560, 36'h7056ff574, 36'h9056ff99f, 36'hd056ff996, 36'hb056fc55f,
        36'hf056fc5ac, 36'hf056fcfef, 36'hf056fcfff, 36'hb056ff564, 36'h4056ff124};

    uaf_top dut (.clock(clock), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .frame_done(frame_done),
        .frame_byte(frame_byte), .frame_bit9(frame_bit9), .frame_stop_ok(frame_stop_ok),
        .serial_mode(serial_mode), .multiproc_enable(multiproc_enable),
        .rx_enable(rx_enable), .tx_ninth_bit(tx_ninth_bit),
        .receive_flag(receive_flag), .received_ninth_bit(received_ninth_bit), .irq(irq));
    uaf_peer peer (.clock(clock), .frame_done(frame_done), .frame_byte(frame_byte),
        .frame_bit9(frame_bit9), .frame_stop_ok(frame_stop_ok));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic report_and_stop();
        if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer, then an idle cycle so no signal is driven twice per step
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= {24'h0, d};
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_total++;
            report_and_stop();
        end
        @(posedge clock);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
        apb(1'b0, a, 8'h00);
        check(rd, e);
        check(32'(er), 32'(ee));
    endtask

    task automatic settle();
        repeat (2) @(posedge clock);
    endtask

    initial begin
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        err_total = 0;
        cmp_count = 0;
        rxd = 32'h0;
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        // every readable register starts at zero
        for (int i = 0; i < 6; i++) rdchk(8'(4 * i), 32'h0, 1'b0);
        apb(1'b1, UAF_OFS_ENABLE, 8'h01);
        // table of ordinary frames, one fresh setup per row
        foreach (rows[i]) begin
            apb(1'b1, UAF_OFS_CONTROL, rows[i][35:28]);
            apb(1'b1, UAF_OFS_OWN_ADDR, rows[i][27:20]);
            apb(1'b1, UAF_OFS_MASK, rows[i][19:12]);
            apb(1'b1, UAF_OFS_CLEAR, 8'h0f);
            peer.send(rows[i][11:4], rows[i][3], rows[i][2]);
            @(posedge clock);
            check(32'(receive_flag), 32'(rows[i][1]));
            check(32'(received_ninth_bit), 32'(rows[i][0]));
            check(32'(irq), 32'(rows[i][1]));
            if (rows[i][1]) rxd = {24'h0, rows[i][11:4]};
            rdchk(UAF_OFS_RX_DATA, rxd, 1'b0);
        end
        // foreign address and bad stop bit leave the flag down but are recorded
        apb(1'b1, UAF_OFS_CONTROL, 8'h70);
        apb(1'b1, UAF_OFS_CLEAR, 8'h0f);
        peer.send(8'h57, 1'b0, 1'b1);
        peer.send(8'h56, 1'b0, 1'b0);
        @(posedge clock);
        check(32'(receive_flag), 32'h0);
        rdchk(UAF_OFS_STATUS, 32'ha, 1'b0);
        // second frame while the flag is up: flag stays, overrun recorded
        apb(1'b1, UAF_OFS_CONTROL, 8'h10);
        apb(1'b1, UAF_OFS_CLEAR, 8'h0f);
        peer.send(8'h21, 1'b0, 1'b1);
        peer.send(8'h22, 1'b0, 1'b1);
        @(posedge clock);
        check(32'(receive_flag), 32'h1);
        rdchk(UAF_OFS_STATUS, 32'h5, 1'b0);
        apb(1'b1, UAF_OFS_ENABLE, 8'h00);
        settle();
        check(32'(irq), 32'h0);
        apb(1'b1, UAF_OFS_ENABLE, 8'h04);
        settle();
        check(32'(irq), 32'h1);
        apb(1'b1, UAF_OFS_CLEAR, 8'h04);
        settle();
        check(32'(irq), 32'h0);
        apb(1'b1, UAF_OFS_STATUS, 8'h00);
        rdchk(UAF_OFS_STATUS, 32'h1, 1'b0);
        // software acknowledge clears the flag
        apb(1'b1, UAF_OFS_CONTROL, 8'h10);
        rdchk(UAF_OFS_CONTROL, 32'h10, 1'b0);
        // mode, multiproc, receive-enable and transmit ninth-bit fields reach their ports
        apb(1'b1, UAF_OFS_CONTROL, 8'hfa);
        check(32'({serial_mode, multiproc_enable, rx_enable, tx_ninth_bit}), 32'h1f);
        rdchk(UAF_OFS_CONTROL, 32'hfa, 1'b0);
        // unmapped place and write-only clear register
        apb(1'b1, 8'h1c, 8'hff);
        check(32'(er), 32'h1);
        rdchk(8'h1c, 32'h0, 1'b1);
        rdchk(UAF_OFS_CLEAR, 32'h0, 1'b0);
        // reset in mid-run returns everything to zero
        srst <= 1'b1;
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        rdchk(UAF_OFS_CONTROL, 32'h0, 1'b0);
        rdchk(UAF_OFS_MASK, 32'h0, 1'b0);
        check(32'({serial_mode, multiproc_enable, rx_enable, tx_ninth_bit}), 32'h0);
        report_and_stop();
    end
endmodule
